// file: src/resolution_gear_select.v
// Resolution select and electronic gear logic with APB register access
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "resolution_gear_select_defines.vh"

// What this block does
// (R1) Two resolution switches pick which of four gear denominators applies.
// (R2) Resolution equals 1000 times gear numerator over selected denominator.
// (R3) A resolution is valid only from 100 to 10000 pulses per revolution.
// (R4) Default parameters give 1000 pulses per revolution.
// (R5) Switch positions are sampled only at power-up.
// (R6) Written parameters are stored but act only after the next power-up.
// (R7) Gear warning whenever any of the four selections is out of range.
// (R8) Power-up while the gear warning stands raises the gear alarm.
// (R9) With switch A off the select input changes resolution during operation.
// (R10) Select low picks denominator 1 or 3, high picks 2 or 4, by switch B.
// (R11) With switch A on the select input is ignored.
// (R12) Select turning on with abnormal warning enabled blocks homing, warns.
// (R13) Controller presets position before asking for home return.
// (R14) Standstill current is a set percentage of the operating current.
// (R15) A setting decides auto return to stop position at current on.
// (R16) A setting picks the shaft direction for forward commands.
// (R17) Enable bits switch anti-vibration and smooth drive.
// (R18) Parameters and switches are shadowed at power-up and used from there.
module resolution_gear_select #(
   parameter DW = 16,
   parameter CW = 8
) (
   input wire clk_i,
   input wire srst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire resolution_switch_a_i,
   input wire resolution_switch_b_i,
   input wire res_select_i,
   input wire preset_i,
   input wire home_return_i,
   input wire [CW-1:0] op_current_i,
   input wire moving_i,
   input wire current_on_i,
   input wire fwd_cmd_i,
   output reg [31:0] resolution_o,
   output reg gear_warn_o,
   output reg gear_alarm_o,
   output reg abn_warn_o,
   output reg home_start_o,
   output reg restore_move_o,
   output reg shaft_dir_o,
   output reg [CW-1:0] motor_current_o,
   output reg antivib_en_o,
   output reg smooth_en_o,
   output reg irq_o
);

   localparam DIV_IDLE = 1'b0;
   localparam DIV_RUN = 1'b1;

   // Resolution 1000*n/d lies in range exactly when these bounds hold
   function in_range;
      input [DW-1:0] n;
      input [DW-1:0] d;
      reg [47:0] p;
      reg [47:0] lo;
      reg [47:0] hi;
      begin
         p = {32'h0000_0000, n} * {16'h0000, `RGS_RES_MULT};
         lo = {32'h0000_0000, d} * {16'h0000, `RGS_RES_MIN};
         hi = {32'h0000_0000, d} * {16'h0000, `RGS_RES_MAX + 32'h0000_0001};
         in_range = (d != {DW{1'b0}}) && (p >= lo) && (p < hi); // [R3]
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [4:0] sync1_q;
   reg [4:0] sync2_q;
   always @(posedge clk_i) begin
      sync1_q <= {home_return_i, preset_i, res_select_i,
                  resolution_switch_b_i, resolution_switch_a_i};
      sync2_q <= sync1_q;
   end
   wire sw_a_pin = sync2_q[0];
   wire sw_b_pin = sync2_q[1];
   wire sel_pin = sync2_q[2];
   wire preset_pin = sync2_q[3];
   wire home_pin = sync2_q[4];

   // ----------------------------------------------------------------
   // Staged parameters written by software
   // ----------------------------------------------------------------
   reg [DW-1:0] den_q [0:3];
   reg [DW-1:0] num_q;
   reg [`RGS_CFG_W-1:0] cfg_q;
   reg [6:0] still_q;
   reg [`RGS_INT_W-1:0] int_stat_q;
   reg [`RGS_INT_W-1:0] int_en_q;
   reg [`RGS_INT_W-1:0] int_evt;

   wire setup = psel_i & ~penable_i;
   wire wr_acc = psel_i & penable_i & pready_o & pwrite_i;
   wire reload_wr = wr_acc & (paddr_i == `RGS_OFS_RELOAD);

   // ----------------------------------------------------------------
   // Power-up pulse: end of reset or a software restart
   // ----------------------------------------------------------------
   reg [1:0] boot_q;
   reg pwrup_q;
   always @(posedge clk_i) begin
      if (srst_i) begin
         boot_q <= 2'h3;
         pwrup_q <= 1'b0;
      end else begin
         if (boot_q != 2'h0)
            boot_q <= boot_q - 2'h1;
         pwrup_q <= (boot_q == 2'h1) | reload_wr;
      end
   end

   // ----------------------------------------------------------------
   // Shadow copy loaded only at power-up
   // ----------------------------------------------------------------
   reg [DW-1:0] sden_q [0:3];
   reg [DW-1:0] snum_q;
   reg [`RGS_CFG_W-1:0] scfg_q;
   reg [6:0] sstill_q;
   reg ssw_a_q;
   reg ssw_b_q;
   integer i;
   integer j;
   always @(posedge clk_i) begin
      if (srst_i) begin
         for (i = 0; i < 4; i = i + 1)
            sden_q[i] <= `RGS_DEN_RST; // [R4]
         snum_q <= `RGS_NUM_RST; // [R4]
         scfg_q <= `RGS_CFG_RST;
         sstill_q <= `RGS_STILL_RST;
         ssw_a_q <= 1'b0;
         ssw_b_q <= 1'b0;
      end else if (pwrup_q) begin
         for (i = 0; i < 4; i = i + 1)
            sden_q[i] <= den_q[i]; // [R6] [R18]
         snum_q <= num_q; // [R6] [R18]
         scfg_q <= cfg_q; // [R6]
         sstill_q <= still_q;
         ssw_a_q <= sw_a_pin; // [R5] [R18]
         ssw_b_q <= sw_b_pin; // [R5]
      end
   end

   // ----------------------------------------------------------------
   // Denominator selection
   // ----------------------------------------------------------------
   // Switch A on forces the odd entry, otherwise the select pin decides
   wire [1:0] sel_idx = {ssw_b_q, ssw_a_q | sel_pin}; // [R1] [R9] [R10] [R11]
   wire all_ok = in_range(snum_q, sden_q[0]) & in_range(snum_q, sden_q[1]) &
                 in_range(snum_q, sden_q[2]) & in_range(snum_q, sden_q[3]);

   // ----------------------------------------------------------------
   // Sequential divider for the active resolution
   // ----------------------------------------------------------------
   reg div_st_q;
   reg [5:0] div_cnt_q;
   reg [31:0] dvd_q;
   reg [31:0] rem_q;
   reg [31:0] quo_q;
   reg [1:0] last_idx_q;
   reg restart_q;
   wire [31:0] rem_sh = {rem_q[30:0], dvd_q[31]};
   wire [31:0] dsr = {16'h0000, sden_q[last_idx_q]};
   wire [47:0] prod = {32'h0000_0000, snum_q} * {16'h0000, `RGS_RES_MULT};
   always @(posedge clk_i) begin
      if (srst_i) begin
         div_st_q <= DIV_IDLE;
         div_cnt_q <= 6'h00;
         dvd_q <= 32'h0000_0000;
         rem_q <= 32'h0000_0000;
         quo_q <= 32'h0000_0000;
         last_idx_q <= 2'h0;
         restart_q <= 1'b1;
         resolution_o <= `RGS_RES_MULT; // [R4]
      end else begin
         last_idx_q <= sel_idx;
         restart_q <= pwrup_q | (sel_idx != last_idx_q); // [R9]
         if (restart_q) begin
            div_st_q <= DIV_RUN;
            div_cnt_q <= `RGS_DIV_STEPS;
            dvd_q <= prod[31:0]; // [R2]
            rem_q <= 32'h0000_0000;
            quo_q <= 32'h0000_0000;
         end else begin
            case (div_st_q)
               DIV_IDLE: begin
                  div_cnt_q <= 6'h00;
               end
               DIV_RUN: begin
                  dvd_q <= {dvd_q[30:0], 1'b0};
                  if (rem_sh >= dsr) begin
                     rem_q <= rem_sh - dsr;
                     quo_q <= {quo_q[30:0], 1'b1};
                  end else begin
                     rem_q <= rem_sh;
                     quo_q <= {quo_q[30:0], 1'b0};
                  end
                  div_cnt_q <= div_cnt_q - 6'h01;
                  if (div_cnt_q == 6'h01) begin
                     div_st_q <= DIV_IDLE;
                     resolution_o <= (rem_sh >= dsr) ? {quo_q[30:0], 1'b1}
                                                     : {quo_q[30:0], 1'b0}; // [R2]
                  end
               end
               default: begin
                  div_st_q <= DIV_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Gear warning, alarm, select warning and homing
   // ----------------------------------------------------------------
   reg sel_prev_q;
   reg preset_prev_q;
   reg home_prev_q;
   reg home_blk_q;
   reg cur_on_prev_q;
   wire sel_rise = sel_pin & ~sel_prev_q & ~ssw_a_q;
   wire abn_set = sel_rise & scfg_q[`RGS_CFG_ABN_EN];
   wire home_req = home_pin & ~home_prev_q;
   wire preset_rise = preset_pin & ~preset_prev_q;
   always @(posedge clk_i) begin
      if (srst_i) begin
         gear_warn_o <= 1'b0;
         gear_alarm_o <= 1'b0;
         abn_warn_o <= 1'b0;
         home_blk_q <= 1'b0;
         home_start_o <= 1'b0;
         sel_prev_q <= 1'b0;
         preset_prev_q <= 1'b0;
         home_prev_q <= 1'b0;
         cur_on_prev_q <= 1'b0;
         restore_move_o <= 1'b0;
      end else begin
         sel_prev_q <= sel_pin;
         preset_prev_q <= preset_pin;
         home_prev_q <= home_pin;
         cur_on_prev_q <= current_on_i;
         gear_warn_o <= ~all_ok; // [R7]
         if (pwrup_q & gear_warn_o)
            gear_alarm_o <= 1'b1; // [R8]
         // A preset in the same cycle as a new select edge leaves it blocked
         if (abn_set) begin
            abn_warn_o <= 1'b1; // [R12]
            home_blk_q <= 1'b1; // [R12]
         end else if (preset_rise) begin
            abn_warn_o <= 1'b0; // [R13]
            home_blk_q <= 1'b0; // [R13]
         end
         home_start_o <= home_req & ~home_blk_q & ~abn_set; // [R12]
         restore_move_o <= current_on_i & ~cur_on_prev_q &
                           scfg_q[`RGS_CFG_RESTORE]; // [R15]
      end
   end

   // ----------------------------------------------------------------
   // Drive outputs from the shadowed configuration
   // ----------------------------------------------------------------
   wire [CW+6:0] still_prod = {7'h00, op_current_i} * {{CW{1'b0}}, sstill_q};
   wire [CW+6:0] still_cur = still_prod / `RGS_PCT_FULL;
   always @(posedge clk_i) begin
      if (srst_i) begin
         shaft_dir_o <= 1'b0;
         motor_current_o <= {CW{1'b0}};
         antivib_en_o <= 1'b0;
         smooth_en_o <= 1'b0;
      end else begin
         shaft_dir_o <= fwd_cmd_i ^ scfg_q[`RGS_CFG_DIR]; // [R16]
         motor_current_o <= moving_i ? op_current_i : still_cur[CW-1:0]; // [R14]
         antivib_en_o <= scfg_q[`RGS_CFG_ANTIVIB]; // [R17]
         smooth_en_o <= scfg_q[`RGS_CFG_SMOOTH]; // [R17]
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, set wins over clear
   // ----------------------------------------------------------------
   always @* begin
      int_evt = {`RGS_INT_W{1'b0}};
      int_evt[`RGS_INT_GEAR_WARN] = ~all_ok & ~gear_warn_o;
      int_evt[`RGS_INT_GEAR_ALARM] = pwrup_q & gear_warn_o;
      int_evt[`RGS_INT_ABN_WARN] = abn_set;
      int_evt[`RGS_INT_HOME_REJ] = home_req & home_blk_q;
   end

   wire [`RGS_INT_W-1:0] clr_mask =
      (wr_acc & (paddr_i == `RGS_OFS_INT_CLR)) ? pwdata_i[`RGS_INT_W-1:0]
                                                : {`RGS_INT_W{1'b0}};
   always @(posedge clk_i) begin
      if (srst_i) begin
         int_stat_q <= {`RGS_INT_W{1'b0}};
         irq_o <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~clr_mask) | int_evt;
         irq_o <= |(((int_stat_q & ~clr_mask) | int_evt) & int_en_q);
      end
   end

   // ----------------------------------------------------------------
   // APB register writes
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (srst_i) begin
         for (j = 0; j < 4; j = j + 1)
            den_q[j] <= `RGS_DEN_RST;
         num_q <= `RGS_NUM_RST;
         cfg_q <= `RGS_CFG_RST;
         still_q <= `RGS_STILL_RST;
         int_en_q <= {`RGS_INT_W{1'b0}};
      end else if (wr_acc) begin
         case (paddr_i)
            `RGS_OFS_DEN1: den_q[0] <= pwdata_i[DW-1:0]; // [R6]
            `RGS_OFS_DEN2: den_q[1] <= pwdata_i[DW-1:0];
            `RGS_OFS_DEN3: den_q[2] <= pwdata_i[DW-1:0];
            `RGS_OFS_DEN4: den_q[3] <= pwdata_i[DW-1:0];
            `RGS_OFS_NUM: num_q <= pwdata_i[DW-1:0];
            `RGS_OFS_CFG: cfg_q <= pwdata_i[`RGS_CFG_W-1:0];
            `RGS_OFS_STILL: still_q <= pwdata_i[6:0];
            `RGS_OFS_INT_EN: int_en_q <= pwdata_i[`RGS_INT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB read data and response, prepared in the setup cycle
   // ----------------------------------------------------------------
   reg [31:0] rd_d;
   reg err_d;
   always @* begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr_i)
         `RGS_OFS_DEN1: rd_d[DW-1:0] = den_q[0];
         `RGS_OFS_DEN2: rd_d[DW-1:0] = den_q[1];
         `RGS_OFS_DEN3: rd_d[DW-1:0] = den_q[2];
         `RGS_OFS_DEN4: rd_d[DW-1:0] = den_q[3];
         `RGS_OFS_NUM: rd_d[DW-1:0] = num_q;
         `RGS_OFS_CFG: rd_d[`RGS_CFG_W-1:0] = cfg_q;
         `RGS_OFS_STILL: rd_d[6:0] = still_q;
         `RGS_OFS_RELOAD: rd_d = 32'h0000_0000;
         `RGS_OFS_RES: rd_d = resolution_o;
         `RGS_OFS_STATUS: rd_d[8:0] = {div_st_q, sel_idx, ssw_b_q, ssw_a_q,
                                       home_blk_q, abn_warn_o, gear_alarm_o,
                                       gear_warn_o};
         `RGS_OFS_INT_STAT: rd_d[`RGS_INT_W-1:0] = int_stat_q;
         `RGS_OFS_INT_CLR: rd_d = 32'h0000_0000;
         `RGS_OFS_INT_EN: rd_d[`RGS_INT_W-1:0] = int_en_q;
         default: err_d = 1'b1;
      endcase
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= setup;
         if (setup) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
            pslverr_o <= err_d;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

endmodule // resolution_gear_select

// file: src/resolution_gear_select_defines.vh
// Constants for the resolution select and electronic gear block
`ifndef RESOLUTION_GEAR_SELECT_DEFINES_VH
`define RESOLUTION_GEAR_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RGS_OFS_DEN1 12'h000
`define RGS_OFS_DEN2 12'h004
`define RGS_OFS_DEN3 12'h008
`define RGS_OFS_DEN4 12'h00C
`define RGS_OFS_NUM 12'h010
`define RGS_OFS_CFG 12'h014
`define RGS_OFS_STILL 12'h018
`define RGS_OFS_RELOAD 12'h01C
`define RGS_OFS_RES 12'h020
`define RGS_OFS_STATUS 12'h024
`define RGS_OFS_INT_STAT 12'h028
`define RGS_OFS_INT_CLR 12'h02C
`define RGS_OFS_INT_EN 12'h030

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define RGS_CFG_ANTIVIB 0
`define RGS_CFG_SMOOTH 1
`define RGS_CFG_DIR 2
`define RGS_CFG_RESTORE 3
`define RGS_CFG_ABN_EN 4
`define RGS_CFG_W 5
`define RGS_CFG_RST 5'h00

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define RGS_INT_GEAR_WARN 0
`define RGS_INT_GEAR_ALARM 1
`define RGS_INT_ABN_WARN 2
`define RGS_INT_HOME_REJ 3
`define RGS_INT_W 4

// ----------------------------------------------------------------
// Reset values and resolution arithmetic
// ----------------------------------------------------------------
`define RGS_DEN_RST 16'h0001
`define RGS_NUM_RST 16'h0001
`define RGS_STILL_RST 7'h32
`define RGS_RES_MULT 32'h0000_03E8
`define RGS_RES_MIN 32'h0000_0064
`define RGS_RES_MAX 32'h0000_2710
`define RGS_PCT_FULL 15'h0064
`define RGS_DIV_STEPS 6'h20

`endif

// file: verif/resolution_gear_select_chk.sv
// Concurrent checks on the ports of the resolution select and gear block
`timescale 1ns/1ps
module resolution_gear_select_chk #(
   parameter CW = 8
) (
   input wire clk_i,
   input wire srst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pready_o,
   input wire pslverr_o,
   input wire res_select_i,
   input wire preset_i,
   input wire home_return_i,
   input wire [CW-1:0] op_current_i,
   input wire moving_i,
   input wire [CW-1:0] motor_current_o,
   input wire home_start_o,
   input wire restore_move_o,
   input wire gear_alarm_o,
   input wire abn_warn_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_preset_rise;
      $rose(preset_i);
   endsequence
   sequence s_home_pulse;
      home_start_o ##1 !home_start_o;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_apb_answer;
      s_setup |=> pready_o ##1 !pready_o;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("pready not in access cycle");
   property p_slverr;
      pslverr_o |-> pready_o;
   endproperty
   a_slverr: assert property (p_slverr) else $error("pslverr without pready");
   property p_home_once;
      $rose(home_start_o) |-> s_home_pulse;
   endproperty
   a_home_once: assert property (p_home_once) else $error("home start not one cycle");
   property p_home_cause;
      home_start_o |-> $past(home_return_i, 3) && !$past(home_return_i, 4);
   endproperty
   a_home_cause: assert property (p_home_cause) else $error("home start without request");
   property p_abn_raise;
      $rose(abn_warn_o) |-> $past(res_select_i, 3) && !$past(res_select_i, 4);
   endproperty
   a_abn_raise: assert property (p_abn_raise) else $error("abnormal warning w/o select");
   property p_abn_clear;
      s_preset_rise |-> ##3 !abn_warn_o;
   endproperty
   a_abn_clear: assert property (p_abn_clear) else $error("preset did not clear warning");
   property p_alarm_sticky;
      gear_alarm_o |=> gear_alarm_o;
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky) else $error("gear alarm dropped");
   property p_restore_pulse;
      restore_move_o |=> !restore_move_o;
   endproperty
   a_restore_pulse: assert property (p_restore_pulse) else $error("restore pulse too long");
   property p_run_current;
      moving_i && !$past(srst_i) |=> motor_current_o == $past(op_current_i);
   endproperty
   a_run_current: assert property (p_run_current) else $error("running current wrong");
endmodule // resolution_gear_select_chk

bind resolution_gear_select resolution_gear_select_chk #(.CW(CW)) i_chk (
   .clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .res_select_i,
   .preset_i, .home_return_i, .op_current_i, .moving_i, .motor_current_o,
   .home_start_o, .restore_move_o, .gear_alarm_o, .abn_warn_o
);

// file: verif/host_ctrl_model.sv
// Host motion controller model driving the select, preset and home pins
`timescale 1ns/1ps
module host_ctrl_model (
   input wire logic clk_i,
   output logic res_select_o,
   output logic preset_o,
   output logic home_return_o
);
   initial begin
      res_select_o = 1'b0;
      preset_o = 1'b0;
      home_return_o = 1'b0;
   end
   task automatic set_select(input logic v);
      @(posedge clk_i);
      res_select_o <= v;
   endtask
   task automatic pulse(input logic home, input int width);
      @(posedge clk_i);
      if (home) home_return_o <= 1'b1;
      else preset_o <= 1'b1;
      repeat (width) @(posedge clk_i);
      preset_o <= 1'b0;
      home_return_o <= 1'b0;
   endtask
   // Preset confirms home before the request; gap sets a prompt or slow host
   task automatic home_seq(input logic with_preset, input int gap);
      if (with_preset) pulse(1'b0, 4);
      repeat (gap) @(posedge clk_i);
      pulse(1'b1, 4);
   endtask
endmodule // host_ctrl_model

// file: verif/tb_top.sv
// Self-checking testbench for the resolution select and gear block
`timescale 1ns/1ps
`include "resolution_gear_select_defines.vh"
module tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic resolution_switch_a_i = 1'b0;
   logic resolution_switch_b_i = 1'b0;
   logic [7:0] op_current_i = 8'hC8;
   logic moving_i = 1'b0;
   logic current_on_i = 1'b0;
   logic fwd_cmd_i = 1'b0;
   wire res_select_i, preset_i, home_return_i, pready_o, pslverr_o, irq_o;
   wire gear_warn_o, gear_alarm_o, abn_warn_o, home_start_o, restore_move_o;
   wire shaft_dir_o, antivib_en_o, smooth_en_o;
   wire [31:0] prdata_o, resolution_o;
   wire [7:0] motor_current_o;
   int num_errors = 0;
   int samples_checked = 0;
   int home_cnt = 0;
   int rest_cnt = 0;
   logic [31:0] rdata;
   logic rerr;
   typedef struct packed {
      logic [15:0] num;
      logic [3:0][15:0] den;
      logic sa, sb, sel;
      logic [31:0] res;
      logic warn;
   } row_t;
   localparam logic [63:0] DS = {16'h0005, 16'h0004, 16'h0002, 16'h000A};
   row_t rows [8] = '{
      '{16'h0001, DS, 1'b0, 1'b0, 1'b0, 32'h0000_0064, 1'b0},
      '{16'h0001, DS, 1'b0, 1'b0, 1'b1, 32'h0000_01F4, 1'b0},
      '{16'h0001, DS, 1'b0, 1'b1, 1'b0, 32'h0000_00FA, 1'b0},
      '{16'h0001, DS, 1'b0, 1'b1, 1'b1, 32'h0000_00C8, 1'b0},
      '{16'h0001, DS, 1'b1, 1'b0, 1'b0, 32'h0000_01F4, 1'b0},
      '{16'h0001, DS, 1'b1, 1'b1, 1'b0, 32'h0000_00C8, 1'b0},
      '{16'h000A, 64'h0001_0001_0001_0001, 1'b0, 1'b0, 1'b0, 32'h0000_2710, 1'b0},
      '{16'h0001, 64'h0000_0001_000B_0001, 1'b0, 1'b0, 1'b0, 32'h0000_03E8, 1'b1}
   };

   resolution_gear_select i_resolution_gear_select (
      .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .resolution_switch_a_i,
      .resolution_switch_b_i, .res_select_i, .preset_i, .home_return_i,
      .op_current_i, .moving_i, .current_on_i, .fwd_cmd_i, .resolution_o,
      .gear_warn_o, .gear_alarm_o, .abn_warn_o, .home_start_o, .restore_move_o,
      .shaft_dir_o, .motor_current_o, .antivib_en_o, .smooth_en_o, .irq_o
   );
   host_ctrl_model i_host (
      .clk_i(clk_i),
      .res_select_o(res_select_i),
      .preset_o(preset_i),
      .home_return_o(home_return_i)
   );

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (home_start_o === 1'b1) home_cnt++;
      if (restore_move_o === 1'b1) rest_cnt++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rdata = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic power_up();
      apb(1'b1, `RGS_OFS_RELOAD, 32'h0);
      repeat (60) @(posedge clk_i);
   endtask

   initial begin
      repeat (10000) @(posedge clk_i);
      num_errors++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      check(resolution_o, 32'h0000_03E8);
      check(motor_current_o, 8'h64);
      check(irq_o, 1'b0);
      foreach (rows[i]) begin
         resolution_switch_a_i <= rows[i].sa;
         resolution_switch_b_i <= rows[i].sb;
         apb(1'b1, `RGS_OFS_NUM, {16'h0, rows[i].num});
         for (int k = 0; k < 4; k++) apb(1'b1, 12'(4 * k), {16'h0, rows[i].den[k]});
         power_up();
         i_host.set_select(rows[i].sel);
         repeat (60) @(posedge clk_i);
         check(resolution_o, rows[i].res);
         check(gear_warn_o, rows[i].warn);
      end
      check(irq_o, 1'b0);
      apb(1'b0, `RGS_OFS_INT_STAT, 32'h0);
      check(rdata[0], 1'b1);
      apb(1'b1, `RGS_OFS_INT_EN, 32'h0000_0001);
      repeat (3) @(posedge clk_i);
      check(irq_o, 1'b1);
      apb(1'b1, `RGS_OFS_INT_CLR, 32'h0000_0001);
      repeat (3) @(posedge clk_i);
      check(irq_o, 1'b0);
      power_up();
      check(gear_alarm_o, 1'b1);
      apb(1'b0, 12'h3FC, 32'h0);
      check(rerr, 1'b1);
      check(rdata, 32'h0);
      srst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      check(gear_alarm_o, 1'b0);
      apb(1'b1, `RGS_OFS_DEN1, 32'h0000_0002);
      resolution_switch_a_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      check(resolution_o, 32'h0000_03E8);
      power_up();
      check(resolution_o, 32'h0000_03E8);
      resolution_switch_a_i <= 1'b0;
      power_up();
      check(resolution_o, 32'h0000_01F4);
      apb(1'b0, `RGS_OFS_RES, 32'h0);
      check(rdata, 32'h0000_01F4);
      apb(1'b1, `RGS_OFS_CFG, 32'h0000_000F);
      apb(1'b1, `RGS_OFS_STILL, 32'h0000_0019);
      check(antivib_en_o, 1'b0);
      power_up();
      fwd_cmd_i <= 1'b1;
      current_on_i <= 1'b1;
      check(antivib_en_o, 1'b1);
      check(smooth_en_o, 1'b1);
      repeat (4) @(posedge clk_i);
      check(shaft_dir_o, 1'b0);
      check(motor_current_o, 8'h32);
      check(rest_cnt, 1);
      moving_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(motor_current_o, 8'hC8);
      apb(1'b1, `RGS_OFS_CFG, 32'h0000_0010);
      current_on_i <= 1'b0;
      power_up();
      current_on_i <= 1'b1;
      i_host.set_select(1'b1);
      repeat (6) @(posedge clk_i);
      check(abn_warn_o, 1'b1);
      i_host.home_seq(1'b0, 2);
      repeat (8) @(posedge clk_i);
      check(home_cnt, 0);
      check(rest_cnt, 1);
      apb(1'b0, `RGS_OFS_INT_STAT, 32'h0);
      check(rdata[3], 1'b1);
      i_host.home_seq(1'b1, 4);
      repeat (8) @(posedge clk_i);
      check(home_cnt, 1);
      check(abn_warn_o, 1'b0);
      apb(1'b0, `RGS_OFS_STATUS, 32'h0);
      check(rdata, 32'h0000_0040);
      final_report();
   end
endmodule // tb_top
